//--- shared/mto_pkg.sv
// Package of constants and types for the timer mode and output control block
package mto_pkg;
  // Register offsets (printed offsets are not multiples of four: index, byte = 4*index)
  localparam logic [7:0]  IDX_TIMER_MODE      = 8'hF9;
  localparam logic [7:0]  IDX_EXT_INPUT_CTRL  = 8'hFA;
  localparam logic [7:0]  IDX_PRESCALER       = 8'hFB;
  localparam logic [7:0]  IDX_OUTPUT_A_CTRL   = 8'hFC;
  localparam logic [7:0]  IDX_OUTPUT_B_CTRL   = 8'hFD;
  localparam logic [7:0]  IDX_EVENT_FLAGS     = 8'hFE;
  localparam logic [7:0]  IDX_IRQ_CTRL        = 8'hFF;
  localparam logic [7:0]  IDX_STATUS          = 8'hF8;
  localparam int          ADDR_W              = 12;
  // Reset values
  localparam logic [7:0]  RST_BYTE            = 8'h00;
  // Timer mode bit positions
  localparam int          TM_OUT_B_EN         = 7;
  localparam int          TM_OUT_A_EN         = 6;
  localparam int          TM_DUAL             = 5;
  localparam int          TM_REG1             = 4;
  localparam int          TM_REG0             = 3;
  localparam int          TM_CLKSRC           = 2;
  localparam int          TM_RETRIG_DIS       = 1;
  localparam int          TM_ONE_SHOT         = 0;
  // Output control field positions
  localparam int          OC_CMP0_LSB         = 6;
  localparam int          OC_CMP1_LSB         = 4;
  localparam int          OC_WRAP_LSB         = 2;
  localparam int          OC_EVT              = 1;
  localparam int          OC_PRESET           = 0;
  // Flag and irq control bit positions
  localparam int          FL_CAP0             = 7;
  localparam int          FL_CAP1             = 6;
  localparam int          FL_COMBINE          = 0;
  localparam int          IC_GLOBAL_EN        = 7;
  localparam int          IC_CAP0_MASK        = 5;
  // Pin actions
  localparam logic [1:0]  ACT_SET             = 2'h0;
  localparam logic [1:0]  ACT_TOGGLE          = 2'h1;
  localparam logic [1:0]  ACT_RESET           = 2'h2;
  localparam logic [1:0]  ACT_NOP             = 2'h3;
  // Edge selection
  localparam logic [1:0]  EDGE_NONE           = 2'h0;
  localparam logic [1:0]  EDGE_FALL           = 2'h1;
  localparam logic [1:0]  EDGE_RISE           = 2'h2;
  localparam logic [1:0]  EDGE_BOTH           = 2'h3;

  // Operating modes
  typedef enum logic [2:0] {
    MTO_LOAD_MONITOR, MTO_LOAD_CAPTURE, MTO_CAPTURE_MONITOR,
    MTO_CAPTURE_CAPTURE, MTO_DOUBLE_LOAD, MTO_DOUBLE_CAPTURE
  } mto_mode_e;

  // Input pin roles
  typedef enum logic [3:0] {
    MTO_ROLE_UNUSED, MTO_ROLE_GATE, MTO_ROLE_TRIGGER, MTO_ROLE_EXT_CLOCK,
    MTO_ROLE_CLOCK_UP, MTO_ROLE_CLOCK_DOWN, MTO_ROLE_UP_DOWN,
    MTO_ROLE_TRIG_UP, MTO_ROLE_TRIG_DOWN, MTO_ROLE_AUTODISCR
  } mto_role_e;
endpackage

//--- logic/mto_ctrl.sv
// Timer mode, input role, prescaler and output pin control with APB registers
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
module mto_ctrl #(
  parameter bit PARALLEL_CAPABLE = 1'b1        // Instance may enter parallel mode
) (
  input  wire logic        clk,                // System clock, 10 MHz
  input  wire logic        sys_rst,            // Synchronous reset, active high
  input  wire logic        psel,               // APB select
  input  wire logic        penable,            // APB enable
  input  wire logic        pwrite,             // APB direction
  input  wire logic [11:0] paddr,              // APB byte address
  input  wire logic [31:0] pwdata,             // APB write data
  output logic      [31:0] prdata,             // APB read data
  output logic             pready,             // APB ready
  output logic             pslverr,            // APB error
  input  wire logic        timer_input_a,      // External input A pin
  input  wire logic        timer_input_b,      // External input B pin
  input  wire logic        compare0_match,     // Core compare0 event pulse
  input  wire logic        compare1_match,     // Core compare1 event pulse
  input  wire logic        counter_wrap,       // Core overflow/underflow pulse
  input  wire logic        capture0_event,     // Core capture into reg0
  input  wire logic        capture1_event,     // Core capture into reg1
  input  wire logic        counter_reload,     // Core reload by software or request
  input  wire logic        prescaler_tick_en,  // Core enables prescaler counting
  output logic             timer_output_a,     // Output A pin
  output logic             timer_output_b,     // Output B pin
  output logic             on_chip_event,      // On-chip event pulse
  output logic             prescaler_tick,     // Prescaler underflow pulse
  output logic             sw_capture0,        // Software load/capture on reg0
  output logic             sw_capture1,        // Software capture on reg1
  output logic             capture_irq,        // Qualified capture interrupt
  output logic      [2:0]  operating_mode,     // Decoded mode, mto_mode_e
  output logic      [3:0]  input_a_role,       // Role of input A, mto_role_e
  output logic      [3:0]  input_b_role,       // Role of input B, mto_role_e
  output logic             input_a_event,      // Selected edge seen on input A
  output logic             input_b_event,      // Selected edge seen on input B
  output logic             parallel_mode,      // Parallel mode active
  output logic             retrigger_en,       // Retriggering allowed
  output logic             one_shot            // One-shot counting
);

  // Apply a two-bit action to a pin level
  function automatic logic apply_act(input logic [1:0] act, input logic lvl);
    unique case (act)
      mto_pkg::ACT_SET:    apply_act = 1'b1;
      mto_pkg::ACT_TOGGLE: apply_act = ~lvl;
      mto_pkg::ACT_RESET:  apply_act = 1'b0;
      mto_pkg::ACT_NOP:    apply_act = lvl;
    endcase
  endfunction

  // AND of action codes of the events present this cycle
  function automatic logic [1:0] merge_act(input logic [7:0] ctl, input logic c0,
                                           input logic c1, input logic wr);
    logic [1:0] a;
    a = mto_pkg::ACT_NOP;
    if (c0) begin
      a = a & ctl[mto_pkg::OC_CMP0_LSB +: 2];
    end
    if (c1) begin
      a = a & ctl[mto_pkg::OC_CMP1_LSB +: 2];
    end
    if (wr) begin
      a = a & ctl[mto_pkg::OC_WRAP_LSB +: 2];
    end
    merge_act = a;
  endfunction

  // Edge detection by selection code
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    unique case (sel)
      mto_pkg::EDGE_NONE: edge_hit = 1'b0;
      mto_pkg::EDGE_FALL: edge_hit = prev & ~cur;
      mto_pkg::EDGE_RISE: edge_hit = ~prev & cur;
      mto_pkg::EDGE_BOTH: edge_hit = prev ^ cur;
    endcase
  endfunction

  logic [7:0] mode_r, icr_r, presc_r, oca_r, ocb_r, irq_r;
  logic       cap0_flag_r, cap1_flag_r, combine_r;
  logic       out_a_r, out_b_r, out_a_nxt, out_b_nxt;
  logic [7:0] pcount_r, pcount_nxt;
  logic       evt_r;
  logic [1:0] ina_sync_r, inb_sync_r;
  logic       ina_prev_r, inb_prev_r;
  logic [31:0] rdata_r;

  // APB decode
  wire        acc      = psel & penable;
  wire        wr_acc   = acc & pwrite;
  wire [9:0]  idx      = paddr[11:2];
  wire        aligned  = (paddr[1:0] == 2'h0);
  wire        hit_mode = aligned && idx == {2'h0, mto_pkg::IDX_TIMER_MODE};
  wire        hit_icr  = aligned && idx == {2'h0, mto_pkg::IDX_EXT_INPUT_CTRL};
  wire        hit_prs  = aligned && idx == {2'h0, mto_pkg::IDX_PRESCALER};
  wire        hit_oca  = aligned && idx == {2'h0, mto_pkg::IDX_OUTPUT_A_CTRL};
  wire        hit_ocb  = aligned && idx == {2'h0, mto_pkg::IDX_OUTPUT_B_CTRL};
  wire        hit_flg  = aligned && idx == {2'h0, mto_pkg::IDX_EVENT_FLAGS};
  wire        hit_irq  = aligned && idx == {2'h0, mto_pkg::IDX_IRQ_CTRL};
  wire        hit_sts  = aligned && idx == {2'h0, mto_pkg::IDX_STATUS};
  wire        hit_any  = hit_mode | hit_icr | hit_prs | hit_oca | hit_ocb
                       | hit_flg | hit_irq | hit_sts;
  wire [7:0]  wb       = pwdata[7:0];
  wire        wr_flg   = wr_acc & hit_flg;

  assign pready  = 1'b1;
  assign pslverr = acc & ~hit_any;

  // Mode decode
  wire        dual = mode_r[mto_pkg::TM_DUAL];
  wire        rm1  = mode_r[mto_pkg::TM_REG1];
  wire        rm0  = mode_r[mto_pkg::TM_REG0];
  mto_pkg::mto_mode_e mode_dec;
  assign mode_dec = dual ? (rm0 ? mto_pkg::MTO_DOUBLE_CAPTURE : mto_pkg::MTO_DOUBLE_LOAD)
                  : ({rm1, rm0} == 2'b00) ? mto_pkg::MTO_LOAD_MONITOR
                  : ({rm1, rm0} == 2'b10) ? mto_pkg::MTO_LOAD_CAPTURE
                  : ({rm1, rm0} == 2'b01) ? mto_pkg::MTO_CAPTURE_MONITOR
                  : mto_pkg::MTO_CAPTURE_CAPTURE;
  assign operating_mode = mode_dec;
  assign parallel_mode = mode_r[mto_pkg::TM_CLKSRC] & PARALLEL_CAPABLE;
  assign retrigger_en  = ~mode_r[mto_pkg::TM_RETRIG_DIS];
  assign one_shot      = mode_r[mto_pkg::TM_ONE_SHOT];

  // Input roles; in parallel mode the roles do not source the prescaler
  mto_pkg::mto_role_e role_a, role_b;
  always_comb begin
    role_a = mto_pkg::MTO_ROLE_UNUSED;
    role_b = mto_pkg::MTO_ROLE_UNUSED;
    unique case (icr_r[7:4])
      4'h0: begin end
      4'h1: role_b = mto_pkg::MTO_ROLE_TRIGGER;
      4'h2: role_a = mto_pkg::MTO_ROLE_GATE;
      4'h3: begin role_a = mto_pkg::MTO_ROLE_GATE; role_b = mto_pkg::MTO_ROLE_TRIGGER; end
      4'h4: role_b = mto_pkg::MTO_ROLE_EXT_CLOCK;
      4'h5: role_a = mto_pkg::MTO_ROLE_TRIGGER;
      4'h6: begin role_a = mto_pkg::MTO_ROLE_GATE; role_b = mto_pkg::MTO_ROLE_EXT_CLOCK; end
      4'h7: begin role_a = mto_pkg::MTO_ROLE_TRIGGER; role_b = mto_pkg::MTO_ROLE_TRIGGER; end
      4'h8: begin role_a = mto_pkg::MTO_ROLE_CLOCK_UP; role_b = mto_pkg::MTO_ROLE_CLOCK_DOWN; end
      4'h9: begin role_a = mto_pkg::MTO_ROLE_UP_DOWN; role_b = mto_pkg::MTO_ROLE_EXT_CLOCK; end
      4'hA: begin role_a = mto_pkg::MTO_ROLE_TRIG_UP; role_b = mto_pkg::MTO_ROLE_TRIG_DOWN; end
      4'hB: role_a = mto_pkg::MTO_ROLE_UP_DOWN;
      4'hC: begin role_a = mto_pkg::MTO_ROLE_AUTODISCR; role_b = mto_pkg::MTO_ROLE_AUTODISCR; end
      4'hD: begin role_a = mto_pkg::MTO_ROLE_TRIGGER; role_b = mto_pkg::MTO_ROLE_EXT_CLOCK; end
      4'hE: begin role_a = mto_pkg::MTO_ROLE_EXT_CLOCK; role_b = mto_pkg::MTO_ROLE_TRIGGER; end
      4'hF: begin role_a = mto_pkg::MTO_ROLE_TRIGGER; role_b = mto_pkg::MTO_ROLE_GATE; end
    endcase
  end
  // roles apply when clock source bit is 0
  assign input_a_role = parallel_mode ? mto_pkg::MTO_ROLE_UNUSED : role_a;
  assign input_b_role = parallel_mode ? mto_pkg::MTO_ROLE_UNUSED : role_b;

  // Pin synchronisers and edge detect on the second stage only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ina_sync_r <= 2'h0;
      inb_sync_r <= 2'h0;
      ina_prev_r <= 1'b0;
      inb_prev_r <= 1'b0;
    end else begin
      ina_sync_r <= {ina_sync_r[0], timer_input_a};
      inb_sync_r <= {inb_sync_r[0], timer_input_b};
      ina_prev_r <= ina_sync_r[1];
      inb_prev_r <= inb_sync_r[1];
    end
  end
  assign input_a_event = edge_hit(icr_r[3:2], ina_prev_r, ina_sync_r[1]);
  assign input_b_event = edge_hit(icr_r[1:0], inb_prev_r, inb_sync_r[1]);

  // Prescaler: counts down, reloads preset on underflow or counter reload
  wire underflow = prescaler_tick_en && pcount_r == 8'h00;
  // preset taken only on underflow or reload
  assign pcount_nxt = (underflow | counter_reload) ? presc_r
                    : prescaler_tick_en ? pcount_r - 8'h01 : pcount_r;
  assign prescaler_tick = underflow;

  // Output pin actions
  wire [1:0] act_a = merge_act(oca_r, compare0_match, compare1_match, counter_wrap);
  wire [1:0] act_b = merge_act(ocb_r, compare0_match, compare1_match, counter_wrap);
  wire       any_evt = compare0_match | compare1_match | counter_wrap;
  assign out_a_nxt = (wr_acc & hit_oca) ? wb[mto_pkg::OC_PRESET]
                   : any_evt ? apply_act(act_a, out_a_r) : out_a_r;
  assign out_b_nxt = (wr_acc & hit_ocb) ? wb[mto_pkg::OC_PRESET]
                   : any_evt ? apply_act(act_b, out_b_r) : out_b_r;
  // output B forced high when disabled
  assign timer_output_b = mode_r[mto_pkg::TM_OUT_B_EN] ? out_b_r : 1'b1;
  // output A forced high when disabled
  assign timer_output_a = mode_r[mto_pkg::TM_OUT_A_EN] ? out_a_r : 1'b1;

  // On-chip event pulse
  wire evt_nxt = (oca_r[mto_pkg::OC_EVT] & compare0_match)
               | (ocb_r[mto_pkg::OC_EVT] & counter_wrap);
  assign on_chip_event = evt_r;

  // Software-set capture flags request captures
  wire sw_set0 = wr_flg & wb[mto_pkg::FL_CAP0] & ~cap0_flag_r;
  wire sw_set1 = wr_flg & wb[mto_pkg::FL_CAP1] & ~cap1_flag_r;
  assign sw_capture0 = sw_set0;
  // no software capture on reg1 in double capture
  assign sw_capture1 = sw_set1 & (mode_dec != mto_pkg::MTO_DOUBLE_CAPTURE);
  // Flags: hardware set wins over software clear
  wire cap0_nxt = capture0_event | sw_set0
                | (cap0_flag_r & ~(wr_flg & ~wb[mto_pkg::FL_CAP0]));
  wire cap1_nxt = capture1_event | sw_set1
                | (cap1_flag_r & ~(wr_flg & ~wb[mto_pkg::FL_CAP1]));

  // Interrupt qualification
  wire cap_comb = combine_r ? (cap0_flag_r & cap1_flag_r) : (cap0_flag_r | cap1_flag_r);
  assign capture_irq = irq_r[mto_pkg::IC_GLOBAL_EN] & irq_r[mto_pkg::IC_CAP0_MASK] & cap_comb;

  // Read mux
  wire [7:0] rd_flg = {cap0_flag_r, cap1_flag_r, 5'h00, combine_r};
  wire [7:0] rd_sts = {1'b0, operating_mode, 1'b0,
                       pcount_r == 8'h00, ina_sync_r[1], inb_sync_r[1]};
  wire [7:0] rd_byte = hit_mode ? mode_r
                     : hit_icr  ? icr_r
                     : hit_prs  ? presc_r
                     : hit_oca  ? {oca_r[7:1], timer_output_a}
                     : hit_ocb  ? {ocb_r[7:1], timer_output_b}
                     : hit_flg  ? rd_flg
                     : hit_irq  ? irq_r
                     : hit_sts  ? rd_sts : 8'h00;
  assign prdata = rdata_r;

  // Read data register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      rdata_r <= {24'h00_0000, rd_byte};
    end
  end

  // Control registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_r  <= mto_pkg::RST_BYTE;
      icr_r   <= mto_pkg::RST_BYTE;
      presc_r <= mto_pkg::RST_BYTE;
      oca_r   <= mto_pkg::RST_BYTE;
      ocb_r   <= mto_pkg::RST_BYTE;
      irq_r   <= mto_pkg::RST_BYTE;
      combine_r <= 1'b0;
    end else if (wr_acc) begin
      if (hit_mode) mode_r <= wb;
      if (hit_icr)  icr_r <= wb;
      if (hit_prs)  presc_r <= wb;
      if (hit_oca)  oca_r <= wb;
      if (hit_ocb)  ocb_r <= wb;
      if (hit_irq)  irq_r <= wb;
      if (hit_flg)  combine_r <= wb[mto_pkg::FL_COMBINE];
    end
  end

  // Pin levels, prescaler, flags and event pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_a_r     <= 1'b0;
      out_b_r     <= 1'b0;
      pcount_r    <= mto_pkg::RST_BYTE;
      cap0_flag_r <= 1'b0;
      cap1_flag_r <= 1'b0;
      evt_r       <= 1'b0;
    end else begin
      out_a_r     <= out_a_nxt;
      out_b_r     <= out_b_nxt;
      pcount_r    <= pcount_nxt;
      cap0_flag_r <= cap0_nxt;
      cap1_flag_r <= cap1_nxt;
      evt_r       <= evt_nxt;
    end
  end

endmodule // mto_ctrl

//--- tb/mto_ctrl_asserts.sv
// Checker of pin, mode and event relations of the timer control block
`timescale 1ns/10ps
module mto_ctrl_asserts #(
  parameter bit PARALLEL_CAPABLE = 1'b1      // Parallel mode allowed
) (
  input wire logic        clk,               // Clock
  input wire logic        sys_rst,           // Reset
  input wire logic        psel,              // APB select
  input wire logic        penable,           // APB enable
  input wire logic        pwrite,            // APB direction
  input wire logic [11:0] paddr,             // APB address
  input wire logic [31:0] pwdata,            // APB write data
  input wire logic        compare0_match,    // Compare0 pulse
  input wire logic        counter_wrap,      // Wrap pulse
  input wire logic        prescaler_tick_en, // Prescaler enable
  input wire logic        timer_output_a,    // Pin A
  input wire logic        timer_output_b,    // Pin B
  input wire logic        on_chip_event,     // Event pulse
  input wire logic        prescaler_tick,    // Underflow pulse
  input wire logic        sw_capture0,       // Soft capture 0
  input wire logic        sw_capture1,       // Soft capture 1
  input wire logic [2:0]  operating_mode,    // Decoded mode
  input wire logic        parallel_mode,     // Parallel mode
  input wire logic        retrigger_en,      // Retrigger allowed
  input wire logic        one_shot           // One-shot
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Write decodes and expected mode
  wire       acc    = psel && penable && pwrite;
  wire       tm_wr  = acc && paddr == {2'b00, mto_pkg::IDX_TIMER_MODE, 2'b00};
  wire       fl_wr  = acc && paddr == {2'b00, mto_pkg::IDX_EVENT_FLAGS, 2'b00};
  wire [2:0] exp_md = pwdata[5] ? {2'b10, pwdata[3]} : {1'b0, pwdata[3], pwdata[4]};
  // Shadow of the prescaler preset, from register writes
  logic [7:0] presc_sh;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      presc_sh <= 8'h00;
    end else if (acc && paddr == {2'b00, mto_pkg::IDX_PRESCALER, 2'b00}) begin
      presc_sh <= pwdata[7:0];
    end
  end
  a_pins_high_reset: assert property ($fell(sys_rst) |-> timer_output_a && timer_output_b)
    else $error("pins not high after reset");
  a_pin_a_off: assert property (tm_wr && !pwdata[6] |=> timer_output_a)
    else $error("disabled pin A not high");
  a_pin_b_off: assert property (tm_wr && !pwdata[7] |=> timer_output_b)
    else $error("disabled pin B not high");
  a_mode_decode: assert property (tm_wr |=> operating_mode == $past(exp_md))
    else $error("operating mode decode wrong");
  a_retrig_oneshot: assert property (tm_wr |=> {retrigger_en, one_shot} == $past(~pwdata[1:0] ^ 2'b01))
    else $error("retrigger or one-shot wrong");
  a_parallel_sel: assert property (tm_wr |=> parallel_mode == ($past(pwdata[2]) && PARALLEL_CAPABLE))
    else $error("parallel mode wrong");
  a_tick_gated: assert property (prescaler_tick_en && prescaler_tick && presc_sh != 8'h00
                                 |=> !prescaler_tick)
    else $error("prescaler ticks too often");
  a_event_cause: assert property (on_chip_event |-> $past(compare0_match) || $past(counter_wrap))
    else $error("event pulse without cause");
  a_swcap0_write: assert property (sw_capture0 |-> fl_wr && pwdata[7])
    else $error("soft capture0 without flag write");
  a_swcap1_mode: assert property (sw_capture1 |-> fl_wr && pwdata[6] && operating_mode != 3'h5)
    else $error("soft capture1 wrong");
  c_event: cover property (on_chip_event);
  c_swcap0: cover property (sw_capture0);
  c_tick: cover property (prescaler_tick);
endmodule // mto_ctrl_asserts

bind mto_ctrl mto_ctrl_asserts #(.PARALLEL_CAPABLE(PARALLEL_CAPABLE)) mto_ctrl_asserts_inst (
  .clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .compare0_match, .counter_wrap,
  .prescaler_tick_en, .timer_output_a, .timer_output_b, .on_chip_event, .prescaler_tick,
  .sw_capture0, .sw_capture1, .operating_mode, .parallel_mode, .retrigger_en, .one_shot);

//--- tb/mto_pin_model.sv
// Model of the board pins that feed the external timer inputs
`timescale 1ns/10ps
module mto_pin_model (
  input  wire logic want_a,        // Requested level on input A
  input  wire logic want_b,        // Requested level on input B
  output wire logic timer_input_a, // Input A pin
  output wire logic timer_input_b  // Input B pin
);
  // Pins follow requests with a delay unrelated to the clock
  assign #37 timer_input_a = want_a;
  assign #37 timer_input_b = want_b;
endmodule // mto_pin_model

//--- tb/testbench.sv
// Self-checking testbench of the timer mode and output control block
`timescale 1ns/10ps
module testbench;
  localparam logic [7:0] TM = mto_pkg::IDX_TIMER_MODE;
  localparam logic [7:0] EX = mto_pkg::IDX_EXT_INPUT_CTRL;
  localparam logic [7:0] OA = mto_pkg::IDX_OUTPUT_A_CTRL;
  localparam logic [7:0] FL = mto_pkg::IDX_EVENT_FLAGS;
  localparam logic [7:0] IQ = mto_pkg::IDX_IRQ_CTRL;
  logic        clk, sys_rst, psel, penable, pwrite, prescaler_tick_en, want_a, want_b, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0]  core;
  logic [7:0]  rd;
  logic        pready, pslverr, timer_input_a, timer_input_b, timer_output_a, timer_output_b;
  logic        on_chip_event, prescaler_tick, sw_capture0, sw_capture1, capture_irq;
  logic        input_a_event, input_b_event, parallel_mode, retrigger_en, one_shot;
  logic [2:0]  operating_mode;
  logic [3:0]  input_a_role, input_b_role;
  int          error_cnt, comparisons, cyc, gap, last, n_evt, n_sc0, n_sc1, n_ea, n_eb;

  mto_ctrl #(.PARALLEL_CAPABLE(1'b1)) mto_ctrl_inst (
    .clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .timer_input_a, .timer_input_b, .compare0_match(core[0]), .compare1_match(core[1]),
    .counter_wrap(core[2]), .capture0_event(core[3]), .capture1_event(core[4]),
    .counter_reload(core[5]), .prescaler_tick_en, .timer_output_a, .timer_output_b,
    .on_chip_event, .prescaler_tick, .sw_capture0, .sw_capture1, .capture_irq,
    .operating_mode, .input_a_role, .input_b_role, .input_a_event, .input_b_event,
    .parallel_mode, .retrigger_en, .one_shot);
  mto_pin_model mto_pin_model_inst (.want_a, .want_b, .timer_input_a, .timer_input_b);

  // Clock of 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Cycle count and hang limit
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  // Pulse counters sampled mid-cycle
  always @(negedge clk) begin
    if (prescaler_tick === 1'b1) begin
      gap = cyc - last;
      last = cyc;
    end
    n_evt += (on_chip_event === 1'b1);
    n_sc0 += (sw_capture0 === 1'b1);
    n_sc1 += (sw_capture1 === 1'b1);
    n_ea += (input_a_event === 1'b1);
    n_eb += (input_b_event === 1'b1);
  end

  task automatic close_out();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_c(int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer, held until pready
  task automatic apb(logic w, logic [7:0] idx, logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(logic [7:0] idx, logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk("register", e, rd);
  endtask
  task automatic pulse(logic [5:0] m);
    @(posedge clk);
    core <= m;
    @(posedge clk);
    core <= 6'h00;
  endtask

  task automatic t_reset();
    wait_c(4);
    chk("pins", 2'b11, {timer_output_a, timer_output_b});
    chk("gap", 1, gap);
    chk("retrig", 1'b1, retrigger_en);
    for (int i = 0; i < 3; i++) rdc(TM + i[7:0], 8'h00);
    rdc(FL, 8'h00);
  endtask
  task automatic t_modes();
    logic [2:0] em;
    logic [3:0] rc[3] = '{4'h0, 4'hC, 4'h8};
    logic [7:0] rr[3] = '{8'h00, 8'h99, 8'h45};
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, TM, {2'b00, i[2:0], i[2:0]});
      em = i[2] ? {2'b10, i[0]} : {1'b0, i[0], i[1]};
      wait_c(1);
      chk("mode", em, operating_mode);
      chk("ctl", {i[2], ~i[1], i[0]}, {parallel_mode, retrigger_en, one_shot});
      rdc(TM, {2'b00, i[2:0], i[2:0]});
    end
    apb(1'b1, TM, 8'h00);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, EX, {rc[i], 4'h0});
      wait_c(1);
      chk("roles", rr[i], {input_a_role, input_b_role});
    end
    apb(1'b1, TM, 8'h04);
    wait_c(1);
    chk("parallel roles", 8'h00, {input_a_role, input_b_role});
    apb(1'b1, TM, 8'h00);
  endtask
  task automatic t_prescale();
    apb(1'b1, mto_pkg::IDX_PRESCALER, 8'h03);
    pulse(6'h20);
    wait_c(20);
    chk("gap 4", 4, gap);
    apb(1'b1, mto_pkg::IDX_PRESCALER, 8'h07);
    wait_c(3);
    chk("gap kept", 4, gap);
    wait_c(30);
    chk("gap 8", 8, gap);
  endtask
  task automatic t_outputs();
    logic [7:0] oc[6] = '{8'h3C, 8'h7C, 8'hBD, 8'hFD, 8'h78, 8'hED};
    logic [5:0] pm[6] = '{6'h01, 6'h01, 6'h01, 6'h01, 6'h05, 6'h02};
    logic       ex[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    apb(1'b1, OA, 8'h00);
    wait_c(1);
    chk("pin a off", 1'b1, timer_output_a);
    apb(1'b1, TM, 8'hC0);
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 6; i++) begin
        apb(1'b1, OA + k[7:0], oc[i]);
        pulse(pm[i]);
        wait_c(1);
        chk("pin", ex[i], k ? timer_output_b : timer_output_a);
        rdc(OA + k[7:0], {oc[i][7:1], ex[i]});
      end
    end
  endtask
  task automatic t_events();
    int b;
    apb(1'b1, OA, 8'h3E);
    apb(1'b1, mto_pkg::IDX_OUTPUT_B_CTRL, 8'h3E);
    b = n_evt;
    pulse(6'h01);
    wait_c(3);
    chk("cmp event", b + 1, n_evt);
    pulse(6'h04);
    wait_c(3);
    chk("wrap event", b + 2, n_evt);
    apb(1'b1, OA, 8'h3C);
    apb(1'b1, mto_pkg::IDX_OUTPUT_B_CTRL, 8'h3C);
    pulse(6'h05);
    wait_c(3);
    chk("no event", b + 2, n_evt);
  endtask
  task automatic t_flags();
    int b;
    pulse(6'h08);
    rdc(FL, 8'h80);
    apb(1'b1, FL, 8'h00);
    rdc(FL, 8'h00);
    b = n_sc0;
    apb(1'b1, FL, 8'h80);
    chk("soft cap0", b + 1, n_sc0);
    apb(1'b1, IQ, 8'hA0);
    wait_c(1);
    chk("irq or", 1'b1, capture_irq);
    apb(1'b1, IQ, 8'h20);
    wait_c(1);
    chk("irq off", 1'b0, capture_irq);
    apb(1'b1, IQ, 8'h80);
    wait_c(1);
    chk("irq masked", 1'b0, capture_irq);
    apb(1'b1, IQ, 8'hA0);
    apb(1'b1, FL, 8'h81);
    wait_c(1);
    chk("irq and", 1'b0, capture_irq);
    pulse(6'h10);
    wait_c(1);
    chk("irq and both", 1'b1, capture_irq);
    apb(1'b1, TM, 8'h28);
    apb(1'b1, FL, 8'h01);
    b = n_sc1;
    apb(1'b1, FL, 8'h41);
    chk("soft cap1 dbl", b, n_sc1);
    apb(1'b1, TM, 8'h00);
    apb(1'b1, FL, 8'h01);
    apb(1'b1, FL, 8'h41);
    chk("soft cap1", b + 1, n_sc1);
    apb(1'b0, 8'h00, 8'h00);
    chk("unmapped", 9'h100, {err, rd});
  endtask
  task automatic t_edges();
    int ba;
    int bb;
    int ex[4] = '{0, 1, 1, 2};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, EX, {4'h0, i[1:0], i[1:0]});
      ba = n_ea;
      bb = n_eb;
      want_a <= 1'b1;
      want_b <= 1'b1;
      wait_c(6);
      want_a <= 1'b0;
      want_b <= 1'b0;
      wait_c(6);
      chk("edges a", ba + ex[i], n_ea);
      chk("edges b", bb + ex[i], n_eb);
    end
  endtask

  // Reset, then scenarios in turn
  initial begin
    {psel, penable, pwrite, want_a, want_b, core} = '0;
    paddr = '0;
    pwdata = '0;
    sys_rst = 1'b1;
    prescaler_tick_en = 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_modes();
    t_prescale();
    t_outputs();
    t_events();
    t_flags();
    t_edges();
    close_out();
  end
endmodule // testbench
